// *** crat_converter_result_autotrigger.sv ***
// Result presentation, result lock, auto-trigger and AHB-Lite register slave of the converter
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// Notes on behaviour
// - Each completed conversion writes its 10-bit result into the high and low bytes unless the bytes are locked.
// - Differential channel results are stored as two's complement signed values.
// - Reading the low byte freezes both bytes until the high byte is read.
// - Right justified: bits 9:8 in high 1:0, bits 7:0 in low, rest zero.
// - Left justified: bits 9:2 in high byte, bits 1:0 in low 7:6.
// - Trigger source field acts only while auto triggering is enabled.
// - Auto mode starts a conversion on each rising edge of the selected flag that arrives while enabled and no conversion is still running.
// - Switching from a clear source to a set source counts as a rising edge.
// - Selecting free running never makes a trigger event by itself.
// - Source codes: free run, comparator, ext int 0, T0 cmp, T0 ovf, T1 cmpB, T1 ovf, T1 capture.
// - Bit 4 of the special function control register always reads zero.
// - Setting auto-trigger enable allows starts on the selected trigger's positive edge.
// - Justification changes alter the byte presentation immediately.
// - Conversion-complete flag sets when a conversion finishes and the bytes update.
module crat_converter_result_autotrigger
   import crat_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Converter core
   output logic                   conv_enable,
   output logic                   conv_start,
   output logic [CHAN_W-1:0]      conv_channel,
   input  wire logic              conv_done,
   input  wire logic [RES_W-1:0]  conv_data,
   // Trigger flags, index 0 unused
   input  wire logic [7:0]        trig_flags,
   // Interrupt
   output logic                   irq
);
   logic              wr_stage_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic              rd_stage_reg;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic [31:0]       hrdata_reg;
   logic              cs_en_reg;
   logic              cs_auto_reg;
   logic [CS_MISC_W-1:0] cs_misc_reg;
   logic              flag_reg;
   logic              busy_reg;
   logic              conv_start_reg;
   logic [SRC_W-1:0]  src_sel_reg;
   logic [SFC_MISC_W-1:0] sfc_misc_reg;
   logic              lj_reg;
   logic [CHAN_W-1:0] chan_reg;
   logic [CHAN_W-1:0] conv_chan_reg;
   logic [RES_W-1:0]  result_reg;
   logic              lock_reg;
   logic [IRQ_W-1:0]  irq_stat_reg;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic              accept;
   logic [BYTE_W-1:0] wbyte;
   logic              cs_en_next;
   logic              trig_edge;
   logic              sw_start;
   logic              start_req;
   logic              done_ok;
   logic              update;
   logic              rd_low;
   logic              rd_high;
   logic [BYTE_W-1:0] low_view;
   logic [BYTE_W-1:0] high_view;
   logic [RES_W-1:0]  coded_result;

   function automatic logic wr_hit(input logic stage, input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
      wr_hit = stage && (a == ofs);
   endfunction

   function automatic logic is_diff(input logic [CHAN_W-1:0] ch);
      is_diff = (ch >= CHAN_DIFF_FIRST) && (ch <= CHAN_DIFF_LAST);
   endfunction

   assign accept = hsel && htrans == HTRANS_NONSEQ && hready;
   assign wbyte = hwdata[BYTE_W-1:0];

   // Bus phase tracking: writes complete with no wait, reads take one wait state
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_stage_reg <= 1'b0;
         wr_addr_reg  <= BYTE_RESET;
         rd_stage_reg <= 1'b0;
         rd_addr_reg  <= BYTE_RESET;
      end
      else
      begin
         wr_stage_reg <= accept && hwrite;
         rd_stage_reg <= accept && !hwrite;
         if (accept)
         begin
            wr_addr_reg <= haddr[ADDR_W-1:0];
            rd_addr_reg <= haddr[ADDR_W-1:0];
         end
      end
   end

   assign hreadyout = !rd_stage_reg;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_reg;

   // Byte views follow the justification bit combinationally
   always_comb
   begin
      if (lj_reg)
      begin
         high_view = result_reg[RES_W-1:2];
         low_view  = {result_reg[1:0], 6'h00};
      end
      else
      begin
         high_view = {6'h00, result_reg[RES_W-1:BYTE_W]};
         low_view  = result_reg[BYTE_W-1:0];
      end
   end

   assign rd_low  = rd_stage_reg && rd_addr_reg == OFS_RESULT_LOW;
   assign rd_high = rd_stage_reg && rd_addr_reg == OFS_RESULT_HIGH;

   // Read data captured in the wait cycle; unmapped addresses read zero
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         hrdata_reg <= WORD_ZERO;
      else if (rd_stage_reg)
      begin
         hrdata_reg <= WORD_ZERO;
         unique case (rd_addr_reg)
            OFS_RESULT_LOW:   hrdata_reg[BYTE_W-1:0] <= low_view;
            OFS_RESULT_HIGH:  hrdata_reg[BYTE_W-1:0] <= high_view;
            OFS_SPECIAL_FUNC: hrdata_reg[BYTE_W-1:0] <= {src_sel_reg, 1'b0, sfc_misc_reg};
            OFS_CTRL_STATUS:  hrdata_reg[BYTE_W-1:0] <= {cs_en_reg, busy_reg, cs_auto_reg, flag_reg,
                                                         cs_misc_reg};
            OFS_INPUT_SELECT: hrdata_reg[BYTE_W-1:0] <= {2'h0, lj_reg, chan_reg};
            OFS_IRQ_STATUS:   hrdata_reg[IRQ_W-1:0] <= irq_stat_reg;
            OFS_IRQ_MASK:     hrdata_reg[IRQ_W-1:0] <= irq_mask_reg;
            default:          hrdata_reg <= WORD_ZERO;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         src_sel_reg  <= SRC_FREE_RUN;
         sfc_misc_reg <= '0;
         lj_reg       <= 1'b0;
         chan_reg     <= '0;
         cs_auto_reg  <= 1'b0;
         cs_misc_reg  <= '0;
         irq_mask_reg <= '0;
      end
      else
      begin
         if (wr_hit(wr_stage_reg, wr_addr_reg, OFS_SPECIAL_FUNC))
         begin
            src_sel_reg  <= wbyte[BYTE_W-1:SFC_SRC_LSB];
            sfc_misc_reg <= wbyte[SFC_MISC_W-1:0];
         end
         if (wr_hit(wr_stage_reg, wr_addr_reg, OFS_INPUT_SELECT))
         begin
            lj_reg   <= wbyte[ISEL_LJ_BIT];
            chan_reg <= wbyte[CHAN_W-1:0];
         end
         if (wr_hit(wr_stage_reg, wr_addr_reg, OFS_CTRL_STATUS))
         begin
            cs_auto_reg <= wbyte[CS_AUTO_BIT];
            cs_misc_reg <= wbyte[CS_MISC_W-1:0];
         end
         if (wr_hit(wr_stage_reg, wr_addr_reg, OFS_IRQ_MASK))
            irq_mask_reg <= hwdata[IRQ_W-1:0];
      end
   end

   crat_trigger_sel u_trigger_sel
   (
      .clk       (clk),
      .resetn    (resetn),
      .src_flags (trig_flags),
      .src_sel   (src_sel_reg),
      .trig_edge (trig_edge)
   );

   // Start decision: software start, selected edge, or free-running restart
   always_comb
   begin
      cs_en_next = wr_hit(wr_stage_reg, wr_addr_reg, OFS_CTRL_STATUS) ? wbyte[CS_EN_BIT] : cs_en_reg;
      sw_start   = wr_hit(wr_stage_reg, wr_addr_reg, OFS_CTRL_STATUS) && wbyte[CS_START_BIT];
      done_ok    = conv_done && busy_reg && cs_en_reg;
      start_req  = cs_en_next && (!busy_reg || done_ok) &&
                   (sw_start ||
                    (cs_auto_reg && trig_edge) ||
                    (cs_auto_reg && src_sel_reg == SRC_FREE_RUN && done_ok));
   end

   // Conversion sequencing; disabling aborts a conversion in flight
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cs_en_reg      <= 1'b0;
         busy_reg       <= 1'b0;
         conv_start_reg <= 1'b0;
         conv_chan_reg  <= '0;
      end
      else
      begin
         cs_en_reg      <= cs_en_next;
         conv_start_reg <= start_req;
         if (!cs_en_next)
            busy_reg <= 1'b0;
         else if (start_req)
            busy_reg <= 1'b1;
         else if (done_ok)
            busy_reg <= 1'b0;
         if (start_req)
            conv_chan_reg <= chan_reg;
      end
   end

   assign conv_enable  = cs_en_reg;
   assign conv_start   = conv_start_reg;
   assign conv_channel = conv_chan_reg;

   // Differential results: offset binary turned into two's complement
   assign coded_result = is_diff(conv_chan_reg) ? {~conv_data[RES_W-1], conv_data[RES_W-2:0]}
                                                : conv_data;
   assign update = done_ok && !lock_reg;

   // Result store and lock
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         result_reg <= RESULT_RESET;
         lock_reg   <= 1'b0;
      end
      else
      begin
         if (update)
            result_reg <= coded_result;
         if (rd_low)
            lock_reg <= 1'b1;
         else if (rd_high)
            lock_reg <= 1'b0;
      end
   end

   // Complete flag: hardware set wins over write-one clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flag_reg <= 1'b0;
      else if (update)
         flag_reg <= 1'b1;
      else if (wr_hit(wr_stage_reg, wr_addr_reg, OFS_CTRL_STATUS) && wbyte[CS_FLAG_BIT])
         flag_reg <= 1'b0;
   end

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_stat_reg <= '0;
      else
      begin
         for (int i = 0; i < IRQ_W; i++)
         begin
            if (wr_hit(wr_stage_reg, wr_addr_reg, OFS_IRQ_STATUS) && hwdata[i])
               irq_stat_reg[i] <= 1'b0;
         end
         if (update)
            irq_stat_reg[IRQ_DONE_BIT] <= 1'b1;
         if (done_ok && lock_reg)
            irq_stat_reg[IRQ_DROP_BIT] <= 1'b1;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   a_result_store : assert property (@(posedge clk) disable iff (!resetn)
      update |=> result_reg == $past(coded_result))
      else $error("result not stored on completion");
   a_diff_sign : assert property (@(posedge clk) disable iff (!resetn)
      (update && is_diff(conv_chan_reg)) |=> result_reg[RES_W-1] == !$past(conv_data[RES_W-1]))
      else $error("differential result not signed");
   a_lock_hold : assert property (@(posedge clk) disable iff (!resetn)
      (lock_reg && !rd_high) |=> $stable(result_reg) && lock_reg)
      else $error("locked result changed");
   a_right_layout : assert property (@(posedge clk) disable iff (!resetn)
      (rd_high && !lj_reg) |=> hrdata_reg == {24'h0, 6'h00, $past(result_reg[RES_W-1:BYTE_W])})
      else $error("right-justified high byte wrong");
   a_left_layout : assert property (@(posedge clk) disable iff (!resetn)
      (rd_low && lj_reg) |=> hrdata_reg == {24'h0, $past(result_reg[1:0]), 6'h00})
      else $error("left-justified low byte wrong");
   a_auto_gated : assert property (@(posedge clk) disable iff (!resetn)
      (trig_edge && !cs_auto_reg && !sw_start) |=> !conv_start)
      else $error("trigger acted with auto disabled");
   a_edge_start : assert property (@(posedge clk) disable iff (!resetn)
      (trig_edge && cs_auto_reg && cs_en_next && !busy_reg) |=> conv_start ##1 busy_reg)
      else $error("trigger edge did not start conversion");
   a_reserved_zero : assert property (@(posedge clk) disable iff (!resetn)
      (rd_stage_reg && rd_addr_reg == OFS_SPECIAL_FUNC) |=> !hrdata_reg[SFC_RES_BIT])
      else $error("reserved bit read nonzero");
   a_flag_on_update : assert property (@(posedge clk) disable iff (!resetn)
      update |=> flag_reg && irq_stat_reg[IRQ_DONE_BIT])
      else $error("complete flag not set");
   a_drop_locked : assert property (@(posedge clk) disable iff (!resetn)
      (done_ok && lock_reg) |=> $stable(result_reg) && irq_stat_reg[IRQ_DROP_BIT])
      else $error("locked result not discarded");
endmodule // crat_converter_result_autotrigger

// *** crat_pkg.sv ***
// Register map, field positions and reset values of the converter result and auto-trigger block
package crat_pkg;
   localparam int RES_W = 10;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 8;
   localparam int SRC_W = 3;
   localparam int CHAN_W = 5;
   localparam int IRQ_W = 2;

   localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SPECIAL_FUNC = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

   // Converter control and status fields
   localparam int CS_EN_BIT = 7;
   localparam int CS_START_BIT = 6;
   localparam int CS_AUTO_BIT = 5;
   localparam int CS_FLAG_BIT = 4;
   localparam int CS_MISC_W = 4;
   // Special function control fields
   localparam int SFC_SRC_LSB = 5;
   localparam int SFC_RES_BIT = 4;
   localparam int SFC_MISC_W = 4;
   // Input select fields
   localparam int ISEL_LJ_BIT = 5;
   // Interrupt status bits
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_DROP_BIT = 1;

   localparam logic [SRC_W-1:0] SRC_FREE_RUN = 3'h0;
   localparam logic [CHAN_W-1:0] CHAN_DIFF_FIRST = 5'h08;
   localparam logic [CHAN_W-1:0] CHAN_DIFF_LAST = 5'h1d;

   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// *** crat_trigger_sel.sv ***
// Trigger source selection and rising-edge detector
`timescale 1ns/10ps
module crat_trigger_sel
   import crat_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Source flags, index 0 unused
   input  wire logic [7:0]       src_flags,
   input  wire logic [SRC_W-1:0] src_sel,
   // Trigger edge
   output logic                  trig_edge
);
   logic sel_level;
   logic prev_level_reg;

   // Free-running code selects a constant low level
   always_comb
   begin
      sel_level = (src_sel == SRC_FREE_RUN) ? 1'b0 : src_flags[src_sel];
   end

   // Edge taken from the selected level, so a switch onto a set flag is an edge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         prev_level_reg <= 1'b0;
      else
         prev_level_reg <= sel_level;
   end

   assign trig_edge = sel_level & ~prev_level_reg;

   a_switch_edge : assert property (@(posedge clk) disable iff (!resetn)
      (!$past(sel_level) && src_sel != $past(src_sel) && sel_level) |-> trig_edge)
      else $error("switch onto set flag gave no edge");
   a_free_no_edge : assert property (@(posedge clk) disable iff (!resetn)
      (src_sel == SRC_FREE_RUN) |-> !trig_edge)
      else $error("free-running code produced an edge");
   a_src_decode : assert property (@(posedge clk) disable iff (!resetn)
      (src_sel != SRC_FREE_RUN && src_flags[src_sel] && !$past(sel_level)) |-> trig_edge)
      else $error("selected flag rise not seen");
endmodule // crat_trigger_sel

// *** crat_testbench.sv ***
// Self-checking testbench of the converter result and auto-trigger block
`timescale 1ns/10ps
module testbench;
   import crat_pkg::*;
   logic              clk;
   logic              resetn;
   logic              hsel;
   logic [31:0]       haddr;
   logic [1:0]        htrans;
   logic              hwrite;
   logic [2:0]        hsize;
   logic [31:0]       hwdata;
   wire logic         hready;
   logic [31:0]       hrdata;
   logic              hreadyout;
   logic              hresp;
   logic              conv_enable;
   logic              conv_start;
   logic [CHAN_W-1:0] conv_channel;
   logic              conv_done;
   logic [RES_W-1:0]  conv_data;
   logic [7:0]        trig_flags;
   logic              irq;
   int                fail_count;
   int                num_checks;
   int                starts;
   int                mark;

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   crat_converter_result_autotrigger crat_converter_result_autotrigger_i (
      .clk          (clk),
      .resetn       (resetn),
      .hsel         (hsel),
      .haddr        (haddr),
      .htrans       (htrans),
      .hwrite       (hwrite),
      .hsize        (hsize),
      .hwdata       (hwdata),
      .hready       (hready),
      .hrdata       (hrdata),
      .hreadyout    (hreadyout),
      .hresp        (hresp),
      .conv_enable  (conv_enable),
      .conv_start   (conv_start),
      .conv_channel (conv_channel),
      .conv_done    (conv_done),
      .conv_data    (conv_data),
      .trig_flags   (trig_flags),
      .irq          (irq)
   );

   always #20 clk = ~clk;

   always @(posedge clk)
      if (conv_start === 1'b1)
         starts <= starts + 1;

   task automatic wrap_up;
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Waits for hready high at a rising edge, bounded
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         fail_count++;
         wrap_up();
      end
   endtask

   task automatic bus(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, addr};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr_en;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      wait_ready();
      rdata = hrdata;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
      logic [31:0] dummy;
      bus(1'b1, addr, wdata, dummy);
   endtask

   task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] got;
      bus(1'b0, addr, 32'h0000_0000, got);
      chk(got, exp);
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask

   // Counts conversion starts since the last call
   task automatic chk_starts(input int exp);
      repeat (4) @(posedge clk);
      chk(32'(starts - mark), 32'(exp));
      mark = starts;
   endtask

   // Converter reports one result, then the data lines change
   task automatic finish(input logic [RES_W-1:0] value);
      @(posedge clk);
      conv_done <= 1'b1;
      conv_data <= value;
      @(posedge clk);
      conv_done <= 1'b0;
      conv_data <= ~value;
      repeat (2) @(posedge clk);
   endtask

   task automatic t_reset_and_reserved;
      logic [7:0] ofs [8];
      ofs = '{OFS_RESULT_LOW, OFS_RESULT_HIGH, OFS_SPECIAL_FUNC, OFS_CTRL_STATUS,
              OFS_INPUT_SELECT, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h40};
      foreach (ofs[i])
         rd(ofs[i], 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(OFS_SPECIAL_FUNC, 32'h0000_001f);
      rd(OFS_SPECIAL_FUNC, 32'h0000_000f);
      wr(OFS_SPECIAL_FUNC, 32'h0000_0010);
      rd(OFS_SPECIAL_FUNC, 32'h0000_0000);
      wr(OFS_RESULT_LOW, 32'h0000_00ff);
      rd(OFS_RESULT_LOW, 32'h0000_0000);
      // High byte read releases the lock taken by the low byte read
      rd(OFS_RESULT_HIGH, 32'h0000_0000);
   endtask

   task automatic t_result;
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      wr(OFS_CTRL_STATUS, 32'h0000_00c0);
      chk_starts(1);
      finish(10'h2a5);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(OFS_CTRL_STATUS, 32'h0000_0090);
      rd(OFS_IRQ_STATUS, 32'h0000_0001);
      rd(OFS_RESULT_LOW, 32'h0000_00a5);
      rd(OFS_RESULT_HIGH, 32'h0000_0002);
      wr(OFS_INPUT_SELECT, 32'h0000_0020);
      rd(OFS_RESULT_LOW, 32'h0000_0040);
      rd(OFS_RESULT_HIGH, 32'h0000_00a9);
      wr(OFS_CTRL_STATUS, 32'h0000_0090);
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(OFS_CTRL_STATUS, 32'h0000_0080);
   endtask

   task automatic t_lock;
      wr(OFS_INPUT_SELECT, 32'h0000_0000);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      rd(OFS_RESULT_LOW, 32'h0000_00a5);
      wr(OFS_CTRL_STATUS, 32'h0000_00c0);
      chk_starts(1);
      finish(10'h155);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(OFS_IRQ_STATUS, 32'h0000_0002);
      rd(OFS_CTRL_STATUS, 32'h0000_0080);
      rd(OFS_RESULT_HIGH, 32'h0000_0002);
      rd(OFS_RESULT_LOW, 32'h0000_00a5);
      rd(OFS_RESULT_HIGH, 32'h0000_0002);
      wr(OFS_IRQ_STATUS, 32'h0000_0003);
   endtask

   task automatic t_differential;
      wr(OFS_INPUT_SELECT, {27'h0, CHAN_DIFF_FIRST});
      wr(OFS_CTRL_STATUS, 32'h0000_00c0);
      chk_starts(1);
      chk({27'h0, conv_channel}, {27'h0, CHAN_DIFF_FIRST});
      finish(10'h1ff);
      rd(OFS_RESULT_LOW, 32'h0000_00ff);
      rd(OFS_RESULT_HIGH, 32'h0000_0003);
      wr(OFS_CTRL_STATUS, 32'h0000_0090);
   endtask

   task automatic t_auto;
      wr(OFS_SPECIAL_FUNC, 32'h0000_0020);
      @(posedge clk);
      trig_flags <= 8'h02;
      chk_starts(0);
      trig_flags <= 8'h00;
      wr(OFS_CTRL_STATUS, 32'h0000_00a0);
      for (int code = 1; code < 8; code++)
      begin
         wr(OFS_SPECIAL_FUNC, 32'(code << SFC_SRC_LSB));
         @(posedge clk);
         trig_flags[code] <= 1'b1;
         chk_starts(1);
         finish(10'(code));
         trig_flags <= 8'h00;
      end
      rd(OFS_CTRL_STATUS, 32'h0000_00b0);
      wr(OFS_SPECIAL_FUNC, 32'h0000_0000);
      chk_starts(0);
      wr(OFS_SPECIAL_FUNC, 32'h0000_0020);
      @(posedge clk);
      trig_flags <= 8'h04;
      chk_starts(0);
      wr(OFS_SPECIAL_FUNC, 32'h0000_0040);
      chk_starts(1);
      finish(10'h0aa);
      trig_flags <= 8'h00;
      // Free running: software starts the first, each completion restarts
      wr(OFS_SPECIAL_FUNC, 32'h0000_0000);
      wr(OFS_CTRL_STATUS, 32'h0000_00e0);
      chk_starts(1);
      finish(10'h0ff);
      chk_starts(1);
      wr(OFS_CTRL_STATUS, 32'h0000_0010);
      @(posedge clk);
      chk({31'h0, conv_enable}, 32'h0000_0000);
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      conv_done = 1'b0;
      conv_data = 10'h000;
      trig_flags = 8'h00;
      fail_count = 0;
      num_checks = 0;
      starts = 0;
      mark = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_reset_and_reserved();
      t_result();
      t_lock();
      t_differential();
      t_auto();
      wrap_up();
   end
endmodule // testbench
